// >>> lphs_sequencer.v
// Low-power hold sequencer with APB register access.
// Assumes request, reconfiguration and status pins are asynchronous.
`include "lphs_map.vh"
`default_nettype none
module lphs_sequencer #(
  parameter NOUT = 8,
  parameter WAKE_CYC = `LPHS_WAKE_CYC
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire lp_request_in,
  input wire reconfig_request_n_in,
  input wire status_pin_in,
  input wire ext_wake_clk_in,
  input wire [NOUT-1:0] user_out_in,
  input wire [NOUT-1:0] idle_hold_in,
  input wire [NOUT-1:0] idle_level_in,
  output reg status_pin_out,
  output reg status_pin_oe_out,
  output reg [NOUT-1:0] pin_out,
  output reg [NOUT-1:0] pin_oe_out,
  output reg write_enable_out,
  output reg inputs_enable_out,
  output reg config_done_out,
  output reg global_set_reset_out,
  output reg osc_enable_out
);
  localparam ST_LOAD = 3'd0;
  localparam ST_RUN = 3'd1;
  localparam ST_FILT = 3'd2;
  localparam ST_HOLD = 3'd3;
  localparam ST_WAKE = 3'd4;
  localparam ST_TIMERS = 3'd5;
  localparam [15:0] FILT_CYC = `LPHS_FILTER_CYC;
  localparam [15:0] BLK_CYC = `LPHS_BLOCK_CYC;
  localparam [15:0] LOAD_CYC = `LPHS_CFG_LOAD_CYC;
  localparam [15:0] WK_CYC = WAKE_CYC;

  localparam SEL_NONE = 3'd0;
  localparam SEL_CTRL = 3'd1;
  localparam SEL_TIMING = 3'd2;
  localparam SEL_STATUS = 3'd3;
  localparam SEL_HOLD = 3'd4;

  reg [1:0] req_sync_reg;
  reg [1:0] prog_sync_reg;
  reg [1:0] stat_sync_reg;
  reg [1:0] eclk_sync_reg;
  reg eclk_prev_reg;
  reg [31:0] ctrl_reg;
  reg [31:0] timing_reg;
  reg [2:0] state_reg;
  reg [15:0] cnt_reg;
  reg [3:0] osc_div_reg;
  reg [NOUT-1:0] held_reg;
  reg idle_reg;
  wire req = req_sync_reg[1];
  wire prog_n = prog_sync_reg[1];
  wire stat_hi = stat_sync_reg[1];
  wire en = ctrl_reg[`LPHS_CTRL_ENABLE];
  wire filt = ctrl_reg[`LPHS_CTRL_FILTER];
  wire eclk_rise = eclk_sync_reg[1] & ~eclk_prev_reg;
  wire osc_tick = (osc_div_reg == 4'h0);
  wire tick = ctrl_reg[`LPHS_CTRL_CLKSEL] ? eclk_rise : osc_tick;
  wire tmr_run = (state_reg == ST_TIMERS);
  wire tmr_clr = (state_reg != ST_TIMERS);
  wire rel_done, unl_done;

  // Offset decode; unmapped offsets give none so the bus can refuse them
  function [2:0] lphs_reg_sel(input [11:0] addr);
    if (addr == `LPHS_OFF_CTRL)
      lphs_reg_sel = SEL_CTRL;
    else if (addr == `LPHS_OFF_TIMING)
      lphs_reg_sel = SEL_TIMING;
    else if (addr == `LPHS_OFF_STATUS)
      lphs_reg_sel = SEL_STATUS;
    else if (addr == `LPHS_OFF_HOLDVAL)
      lphs_reg_sel = SEL_HOLD;
    else
      lphs_reg_sel = SEL_NONE;
  endfunction

  wire [2:0] setup_sel = lphs_reg_sel(paddr_in);
  wire wr_access = psel_in & penable_in & pready_out & pwrite_in;

  lphs_wake_timer #(.CW(10)) u_release (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .clear_in(tmr_clr),
    .run_in(tmr_run),
    .tick_in(tick),
    .count_in(timing_reg[9:0]),
    .done_out(rel_done)
  );
  lphs_wake_timer #(.CW(10)) u_unlock (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .clear_in(tmr_clr),
    .run_in(tmr_run),
    .tick_in(tick),
    .count_in(timing_reg[25:16]),
    .done_out(unl_done)
  );

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_sync_reg <= 2'b00;
      prog_sync_reg <= 2'b11;
      stat_sync_reg <= 2'b00;
      eclk_sync_reg <= 2'b00;
      eclk_prev_reg <= 1'b0;
    end else begin
      req_sync_reg <= {req_sync_reg[0], lp_request_in};
      prog_sync_reg <= {prog_sync_reg[0], reconfig_request_n_in};
      stat_sync_reg <= {stat_sync_reg[0], status_pin_in};
      eclk_sync_reg <= {eclk_sync_reg[0], ext_wake_clk_in};
      eclk_prev_reg <= eclk_sync_reg[1];
    end
  end

  // Internal oscillator model: divided tick, divider set to one while the oscillator is off
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in)
      osc_div_reg <= 4'h0;
    else if (osc_enable_out)
      osc_div_reg <= osc_div_reg + 4'h1;
    else
      osc_div_reg <= 4'h1;
  end

  // Writes land at the access edge, the one at which the master sees ready
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_reg <= `LPHS_CTRL_RESET; // [RQ23]
      timing_reg <= `LPHS_TIM_RESET;
    end else if (wr_access) begin
      if (setup_sel == SEL_CTRL)
        ctrl_reg <= {27'h0, pwdata_in[4:0]}; // [RQ24]
      else if (setup_sel == SEL_TIMING)
        timing_reg <= {6'h0, pwdata_in[25:16], 6'h0, pwdata_in[9:0]};
    end
  end

  // Read side: decoded at setup, ready in the access cycle, no wait states
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= 1'b0;
      if (psel_in && !penable_in) begin
        prdata_out <= 32'h0000_0000;
        if (setup_sel == SEL_CTRL) begin
          prdata_out <= ctrl_reg;
        end else if (setup_sel == SEL_TIMING) begin
          prdata_out <= timing_reg;
        end else if (setup_sel == SEL_STATUS) begin
          prdata_out <= {24'h0, write_enable_out, inputs_enable_out, idle_reg,
            status_pin_out, 1'b0, state_reg};
        end else if (setup_sel == SEL_HOLD) begin
          prdata_out <= {{(32-NOUT){1'b0}}, held_reg};
        end else begin
          // Refused: error flagged, nothing written
          pslverr_out <= 1'b1;
        end
      end
    end
  end

  // Sequencer
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_LOAD;
      cnt_reg <= 16'h0;
      held_reg <= {NOUT{1'b0}};
      idle_reg <= 1'b0;
      write_enable_out <= 1'b0;
      inputs_enable_out <= 1'b0;
      config_done_out <= 1'b0;
      global_set_reset_out <= 1'b0;
      osc_enable_out <= 1'b1;
      status_pin_out <= 1'b1;
      status_pin_oe_out <= 1'b0;
    end else if (!prog_n) begin
      state_reg <= ST_LOAD; // [RQ20]
      cnt_reg <= 16'h0;
      idle_reg <= 1'b0;
      write_enable_out <= 1'b0;
      inputs_enable_out <= 1'b0;
      config_done_out <= 1'b0;
      global_set_reset_out <= 1'b0;
      osc_enable_out <= 1'b1;
      status_pin_out <= 1'b1;
      status_pin_oe_out <= 1'b0;
    end else begin
      global_set_reset_out <= 1'b0;
      case (state_reg)
        ST_LOAD: begin
          // Load proceeds whatever the request level
          cnt_reg <= cnt_reg + 16'h1; // [RQ2]
          if (cnt_reg + 16'h1 >= LOAD_CYC) begin
            state_reg <= ST_RUN;
            cnt_reg <= 16'h0;
            config_done_out <= 1'b1;
            write_enable_out <= 1'b1;
            inputs_enable_out <= 1'b1;
            status_pin_out <= 1'b1;
            status_pin_oe_out <= 1'b1;
          end
        end
        ST_RUN: begin
          cnt_reg <= 16'h0;
          if (req && en) begin // [RQ1] [RQ3]
            held_reg <= user_out_in; // [RQ8]
            if (filt) begin
              state_reg <= ST_FILT; // [RQ6]
            end else begin
              state_reg <= ST_HOLD;
              write_enable_out <= 1'b0; // [RQ4]
              status_pin_out <= 1'b0; // [RQ5]
              status_pin_oe_out <= 1'b1;
              idle_reg <= 1'b1; // [RQ7]
            end
          end
        end
        ST_FILT: begin
          // Short request pulses are rejected by the filter
          if (!req) begin
            state_reg <= ST_RUN;
          end else if (cnt_reg + 16'h1 >= FILT_CYC) begin
            state_reg <= ST_HOLD;
            cnt_reg <= 16'h0;
            write_enable_out <= 1'b0; // [RQ4] [RQ6]
            status_pin_out <= 1'b0; // [RQ5]
            status_pin_oe_out <= 1'b1;
            idle_reg <= 1'b1; // [RQ7]
          end else begin
            cnt_reg <= cnt_reg + 16'h1;
          end
        end
        ST_HOLD: begin
          // Config done left high throughout [RQ10]
          if (cnt_reg < BLK_CYC)
            cnt_reg <= cnt_reg + 16'h1;
          if (cnt_reg + 16'h1 == BLK_CYC) begin
            inputs_enable_out <= 1'b0; // [RQ9]
            osc_enable_out <= 1'b0; // [RQ25]
          end
          if (!req && cnt_reg >= BLK_CYC) begin
            state_reg <= ST_WAKE;
            cnt_reg <= 16'h0;
          end
        end
        ST_WAKE: begin
          if (cnt_reg < WK_CYC)
            cnt_reg <= cnt_reg + 16'h1;
          if (cnt_reg + 16'h1 == WK_CYC) begin
            inputs_enable_out <= 1'b1; // [RQ11]
            osc_enable_out <= 1'b1;
            global_set_reset_out <= ctrl_reg[`LPHS_CTRL_GSR]; // [RQ12]
            status_pin_out <= 1'b1; // [RQ13] [RQ14]
            status_pin_oe_out <= ctrl_reg[`LPHS_CTRL_DRIVE];
          end
          // Open-drain: wait for far side to pull high [RQ15]
          if (cnt_reg >= WK_CYC && stat_hi)
            state_reg <= ST_TIMERS; // [RQ16]
        end
        ST_TIMERS: begin
          if (rel_done)
            idle_reg <= 1'b0; // [RQ17] [RQ22]
          if (unl_done) begin
            write_enable_out <= 1'b1; // [RQ18] [RQ21]
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_LOAD;
      endcase
    end
  end

  // Pin muxing: held value on hold pins, other pins released while idle
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_out <= {NOUT{1'b0}};
      pin_oe_out <= {NOUT{1'b0}};
    end else if (idle_reg) begin
      pin_out <= held_reg & idle_hold_in; // [RQ8]
      pin_oe_out <= idle_hold_in; // [RQ7]
    end else begin
      pin_out <= user_out_in;
      pin_oe_out <= {NOUT{config_done_out}};
    end
  end
endmodule
`default_nettype wire

// >>> lphs_map.vh
// Constants for the low-power hold sequencer.
// Assumes one 50 MHz clock; included by the sequencer with its APB registers.
// Behaviour
// (RQ1) Request honoured only when mode enabled
// (RQ2) Power-up configuration load ignores request level
// (RQ3) Enabled request enters low power at once
// (RQ4) Write protect storage immediately on request
// (RQ5) Status pin driven low on entry
// (RQ6) Glitch filter adds entry delay
// (RQ7) Outputs switch to idle behaviour
// (RQ8) Hold-last value captured at request rise
// (RQ9) Inputs and interconnect blocked later
// (RQ10) Configuration-complete stays high while held
// (RQ11) Request low re-enables inputs, storage protected
// (RQ12) Optional global set/reset on wake
// (RQ13) Status pin driven high or released
// (RQ14) Status pin rises after wake delay
// (RQ15) Far side pulls released status pin high
// (RQ16) Wake timers start at status high
// (RQ17) Output release after programmable count
// (RQ18) Write unlock after second programmable count
// (RQ19) Unlock count should exceed release count
// (RQ20) Reconfiguration pulse overrides and reloads
// (RQ21) Write unlock timing from status rise
// (RQ22) Output release timing from status rise
// (RQ23) Feature defaults to disabled
// (RQ24) Glitch filter enabled or bypassed
// (RQ25) Internal oscillator stopped while held
// (RQ26) Counters start on first wake clock edge
`ifndef LPHS_MAP_VH
`define LPHS_MAP_VH
`define LPHS_CLK_MHZ 50
`define LPHS_OFF_CTRL 12'h000
`define LPHS_OFF_TIMING 12'h004
`define LPHS_OFF_STATUS 12'h008
`define LPHS_OFF_HOLDVAL 12'h00c
`define LPHS_CTRL_ENABLE 0
`define LPHS_CTRL_FILTER 1
`define LPHS_CTRL_DRIVE 2
`define LPHS_CTRL_GSR 3
`define LPHS_CTRL_CLKSEL 4
`define LPHS_CTRL_RESET 32'h0000_0000
`define LPHS_TIM_RESET 32'h0005_0004
`define LPHS_FILTER_NS 300
`define LPHS_FILTER_CYC ((`LPHS_FILTER_NS * `LPHS_CLK_MHZ + 999) / 1000)
`define LPHS_BLOCK_NS 340
`define LPHS_BLOCK_CYC ((`LPHS_BLOCK_NS * `LPHS_CLK_MHZ) / 1000)
`define LPHS_WAKE_NS 4000
`define LPHS_WAKE_CYC ((`LPHS_WAKE_NS * `LPHS_CLK_MHZ + 999) / 1000)
`define LPHS_CFG_LOAD_CYC 16
`endif

// >>> lphs_wake_timer.v
// Wake timer: counts selected wake clock edges after status seen high.
// Assumes wake clock tick is a one-cycle pulse in the main clock domain.
`default_nettype none
module lphs_wake_timer #(
  parameter CW = 10
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire clear_in,
  input wire run_in,
  input wire tick_in,
  input wire [CW-1:0] count_in,
  output reg done_out
);
  reg [CW-1:0] cnt_reg;
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg <= {CW{1'b0}};
      done_out <= 1'b0;
    end else if (clear_in) begin
      cnt_reg <= {CW{1'b0}};
      done_out <= 1'b0;
    end else if (run_in && tick_in && !done_out) begin
      // Count of zero treated as one
      cnt_reg <= cnt_reg + 1'b1;
      if (cnt_reg + 1'b1 >= count_in)
        done_out <= 1'b1; // [RQ17] [RQ18] [RQ26]
    end
  end
endmodule
`default_nettype wire

// >>> lphs_seq_props.sv
// Assertions on the low-power hold sequencer ports.
// Assumes the control word at offset 0: enable, filter, wake reset in bits 0, 1, 3.
`default_nettype none
module lphs_seq_props (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic lp_request_in,
  input wire logic reconfig_request_n_in,
  input wire logic status_pin_in,
  input wire logic write_enable_out,
  input wire logic inputs_enable_out,
  input wire logic config_done_out,
  input wire logic global_set_reset_out
);
  logic [3:0] ctl_reg;
  logic [5:0] held_reg;
  // Mirror taken at the access edge, where the design stores the word too
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl_reg <= 4'h0;
      held_reg <= 6'h00;
    end else begin
      if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h000)
        ctl_reg <= pwdata_in[3:0];
      // Saturates so a long hold never wraps into the checked window
      held_reg <= lp_request_in ? held_reg + {5'h00, held_reg != 6'h3f} : 6'h00;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  sequence cfg_steady; reconfig_request_n_in [*4]; endsequence
  sequence cfg_pulse; !reconfig_request_n_in [*3]; endsequence
  a_apb_answer: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready after setup");
  a_entry_lock: assert property (
    ctl_reg[0] && !ctl_reg[1] && held_reg == 6'h05 |-> !write_enable_out)
    else $error("storage not locked on entry");
  a_filter_hold: assert property (
    ctl_reg[0] && ctl_reg[1] && held_reg == 6'h0a |-> write_enable_out)
    else $error("filter passed a short request");
  a_input_block: assert property (
    ctl_reg[0] && !ctl_reg[1] && held_reg == 6'h18 |-> !inputs_enable_out && config_done_out)
    else $error("inputs still open while held");
  a_done_kept: assert property (cfg_steady ##0 config_done_out |=> config_done_out)
    else $error("config done dropped");
  a_reconfig_load: assert property (cfg_pulse |-> ##[0:4] !config_done_out)
    else $error("reload not started");
  a_gsr_gate: assert property (global_set_reset_out |-> ctl_reg[3])
    else $error("wake reset while disabled");
  a_wake_order: assert property (
    $rose(status_pin_in) && config_done_out && !write_enable_out
    |-> (!write_enable_out) [*8] ##[1:600] write_enable_out)
    else $error("write unlock out of window");
endmodule
bind lphs_sequencer lphs_seq_props lphs_seq_props_i (.mclk_in, .nrst_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .lp_request_in,
  .reconfig_request_n_in, .status_pin_in, .write_enable_out, .inputs_enable_out,
  .config_done_out, .global_set_reset_out);
`default_nettype wire

// >>> lphs_ctrl_model.sv
// Model of the system controller on the request and wake status wires.
// Assumes the bench sets the request level and any stall at clock edges.
`default_nettype none
module lphs_ctrl_model (
  input wire logic req_level_in,
  input wire logic hold_low_in,
  input wire logic stat_drv_in,
  input wire logic stat_oe_in,
  output logic lp_request_out,
  output logic status_wire_out,
  output logic wake_clk_out
);
  timeunit 1ns;
  timeprecision 100ps;
  assign lp_request_out = req_level_in;
  // Pull-up when released; holding low models a slow controller
  assign status_wire_out = stat_oe_in ? stat_drv_in : !hold_low_in;
  initial wake_clk_out = 1'b0;
  always #70 wake_clk_out = !wake_clk_out;
endmodule
`default_nettype wire

// >>> tb_lphs_sequencer.sv
// Self-checking bench for the low-power hold sequencer.
// Assumes the controller model drives the request and status wires.
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", n, e, a); end end
module tb_lphs_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic er;} lphs_row_t;
  // Reads compare against d, writes send it
  lphs_row_t rows[5] = '{'{12'h0, 1'b0, 32'h0, 1'b0}, '{12'h4, 1'b0, 32'h50004, 1'b0},
    '{12'h14, 1'b0, 32'h0, 1'b1}, '{12'h4, 1'b1, 32'h50002, 1'b0},
    '{12'h4, 1'b0, 32'h50002, 1'b0}};
  logic mclk_in = 1'b0, nrst_in = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, req = 1'b1;
  logic hold = 1'b0, rcfg_n = 1'b1, gsr_seen = 1'b0, err, pready, pslverr, st_out, st_oe;
  logic st_wire, lp_req, wclk, we, inen, done, gsr, osc;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] uout = 8'ha5, pin, poe;
  int fail_count = 0, samples_checked = 0;
  always #10 mclk_in = !mclk_in;
  always @(posedge mclk_in) if (gsr) gsr_seen <= 1'b1;
  lphs_sequencer #(.WAKE_CYC(20)) lphs_sequencer_i (.mclk_in, .nrst_in, .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .lp_request_in(lp_req),
    .reconfig_request_n_in(rcfg_n), .status_pin_in(st_wire), .ext_wake_clk_in(wclk),
    .user_out_in(uout), .idle_hold_in(8'h0f), .idle_level_in(8'h00), .status_pin_out(st_out),
    .status_pin_oe_out(st_oe), .pin_out(pin), .pin_oe_out(poe), .write_enable_out(we),
    .inputs_enable_out(inen), .config_done_out(done), .global_set_reset_out(gsr),
    .osc_enable_out(osc));
  lphs_ctrl_model lphs_ctrl_model_i (.req_level_in(req), .hold_low_in(hold),
    .stat_drv_in(st_out), .stat_oe_in(st_oe), .lp_request_out(lp_req),
    .status_wire_out(st_wire), .wake_clk_out(wclk));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(posedge mclk_in);
    if (s !== v) begin
      fail_count++;
      finish_test();
    end
  endtask
  // Idles a cycle after each transfer so psel is never set twice in one step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    pen <= 1'b1;
    cyc(1);
    wait_for(pready, 1'b1, 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    cyc(1);
  endtask
  initial begin
    cyc(5);
    nrst_in <= 1'b1;
    cyc(20);
    `CHK("config done", 1'b1, done)
    `CHK("write enable", 1'b1, we)
    req <= 1'b0;
    $display("power-up test done");
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      `CHK("slave error", rows[i].er, err)
      if (!rows[i].w) `CHK("read data", rows[i].d, rd)
    end
    $display("register test done");
    apb(12'h0, 1'b1, 32'h1);
    req <= 1'b1;
    wait_for(we, 1'b0, 6);
    uout <= 8'h5a;
    `CHK("status wire", 1'b0, st_wire)
    cyc(3);
    `CHK("idle enables", 8'h0f, poe)
    `CHK("held value", 8'h05, pin & 8'h0f)
    cyc(25);
    `CHK("inputs", 1'b0, inen)
    `CHK("config done", 1'b1, done)
    `CHK("oscillator", 1'b0, osc)
    hold <= 1'b1;
    req <= 1'b0;
    cyc(60);
    `CHK("inputs", 1'b1, inen)
    `CHK("status drive", 1'b0, st_oe)
    `CHK("write enable", 1'b0, we)
    hold <= 1'b0;
    wait_for(we, 1'b1, 300);
    `CHK("pins", 8'h5a, pin)
    `CHK("wake reset", 1'b0, gsr_seen)
    $display("wake test done");
    apb(12'h0, 1'b1, 32'h1f);
    req <= 1'b1;
    cyc(8);
    req <= 1'b0;
    cyc(30);
    `CHK("write enable", 1'b1, we)
    req <= 1'b1;
    wait_for(we, 1'b0, 40);
    cyc(40);
    req <= 1'b0;
    wait_for(st_wire, 1'b1, 80);
    `CHK("status drive", 1'b1, st_oe)
    wait_for(we, 1'b1, 300);
    cyc(1);
    `CHK("wake reset", 1'b1, gsr_seen)
    $display("filter test done");
    apb(12'h0, 1'b1, 32'h1);
    req <= 1'b1;
    wait_for(we, 1'b0, 6);
    req <= 1'b0;
    rcfg_n <= 1'b0;
    cyc(5);
    `CHK("config done", 1'b0, done)
    rcfg_n <= 1'b1;
    wait_for(done, 1'b1, 60);
    `CHK("write enable", 1'b1, we)
    $display("reconfiguration test done");
    finish_test();
  end
endmodule
`default_nettype wire
